/* logic/lcdc_cmd_decoder.sv */
// command decoder with its bus slave, power sequencing and shift strobe
//
// Added by the designer: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`include "lcdc_map.svh"
module lcdc_cmd_decoder import lcdc_pkg::*; #(
   parameter int TOSS_NS = `LCDC_TOSS_NS
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic panel_power_disable,
   output logic vram_chip_enable_n,
   output logic column_shift_strobe,
   output logic display_enable
);
   localparam int WAKE_CYC = `LCDC_WAKE_TC +
      (TOSS_NS + `LCDC_WAKE_EXTRA_NS + `LCDC_TC_NS - 1) / `LCDC_TC_NS;
   localparam int SLEEP_EXTRA_CYC = `LCDC_SLEEP_EXTRA_NS / `LCDC_TC_NS;

   // parameter count of fixed-length and cursor commands; zero for the rest
   function automatic logic [3:0] pcount(input lcdc_byte_t op);
      case (op)
         `LCDC_OP_INIT: pcount = 4'd8;
         `LCDC_OP_REGION: pcount = 4'd10;
         `LCDC_OP_GLYPH, `LCDC_OP_SHAPE: pcount = 4'd2;
         `LCDC_OP_DISP0, `LCDC_OP_DISP1: pcount = 4'd1;
         `LCDC_OP_PAN, `LCDC_OP_MIX: pcount = 4'd1;
         `LCDC_OP_CURW, `LCDC_OP_CURR: pcount = 4'd2;
         default: pcount = 4'd0;
      endcase
   endfunction

   // first slot of each command's parameters in the store
   function automatic logic [4:0] pbase(input lcdc_byte_t op);
      case (op)
         `LCDC_OP_REGION: pbase = `LCDC_BASE_REGION;
         `LCDC_OP_GLYPH: pbase = `LCDC_BASE_GLYPH;
         `LCDC_OP_SHAPE: pbase = `LCDC_BASE_SHAPE;
         `LCDC_OP_DISP0, `LCDC_OP_DISP1: pbase = `LCDC_BASE_DISP;
         `LCDC_OP_PAN: pbase = `LCDC_BASE_PAN;
         `LCDC_OP_MIX: pbase = `LCDC_BASE_MIX;
         default: pbase = `LCDC_BASE_INIT;
      endcase
   endfunction

   // first half of a two-byte item; pitch bytes are never paired
   function automatic logic pair_first(input lcdc_byte_t op,
         input logic [3:0] idx);
      pair_first = ((op == `LCDC_OP_REGION) && (idx == 4'd0 ||
         idx == 4'd3 || idx == 4'd6 || idx == 4'd8)) ||
         ((op == `LCDC_OP_GLYPH) && (idx == 4'd0));
   endfunction

   // cursor advance by direction: right, left, up, down
   function automatic lcdc_addr_t cursor_step(input lcdc_addr_t c,
         input logic [1:0] dir, input lcdc_addr_t pitch);
      case (dir)
         2'd0: cursor_step = c + 16'h0001;
         2'd1: cursor_step = c - 16'h0001;
         2'd2: cursor_step = c - pitch;
         default: cursor_step = c + pitch;
      endcase
   endfunction

   lcdc_mem_if mem_bus ();
   lcdc_vram u_vram (
      .hclk(hclk),
      .port(mem_bus.mem)
   );

   logic dp_act_reg;
   logic dp_wr_reg;
   logic [7:0] dp_addr_reg;
   lcdc_byte_t op_reg;
   logic [3:0] idx_reg;
   logic pend_reg;
   lcdc_byte_t pend_byte_reg;
   lcdc_addr_t cursor_reg;
   logic [1:0] dir_reg;
   logic disp_reg;
   logic panel_reg;
   lcdc_pwr_e pwr_reg;
   logic [22:0] pwr_cnt_reg;
   logic rd_wait_reg;
   logic div_reg;
   logic strobe_reg;
   lcdc_byte_t par_reg [0:`LCDC_PAR_NUM-1];

   // data phase decode
   wire take = hsel & htrans[1] & hready;
   wire dp_cmd_wr = dp_act_reg & dp_wr_reg & (dp_addr_reg == `LCDC_CMD_OFS);
   wire dp_dat_wr = dp_act_reg & dp_wr_reg &
      (dp_addr_reg == `LCDC_DATA_OFS);
   wire dp_dat_rd = dp_act_reg & ~dp_wr_reg &
      (dp_addr_reg == `LCDC_DATA_OFS);
   wire vram_wr_req = dp_dat_wr & (op_reg == `LCDC_OP_MWR);
   wire vram_rd_req = dp_dat_rd & (op_reg == `LCDC_OP_MRD);
   wire waking = (pwr_reg == PWR_WAKE);
   // a memory access stalls the bus while the oscillator settles
   wire vram_hold = (vram_wr_req | vram_rd_req) & waking;
   wire rd_issue = vram_rd_req & ~waking & ~rd_wait_reg;
   assign hreadyout = ~(vram_hold | rd_issue);
   assign hresp = 1'b0;

   // events seen by the decoder, one per accepted transfer
   wire lcdc_byte_t bus_byte = hwdata[7:0];
   wire cmd_evt = dp_cmd_wr;
   wire dat_evt = dp_dat_wr & hreadyout;
   wire rd_done = dp_dat_rd & hreadyout;
   wire [3:0] pcnt = pcount(op_reg);
   wire in_range = idx_reg < pcnt;
   wire fixed_cmd = (op_reg != `LCDC_OP_CURW) &&
      (op_reg != `LCDC_OP_CURR);
   wire par_evt = dat_evt & in_range & fixed_cmd;
   wire [4:0] slot = pbase(op_reg) + {1'b0, idx_reg};
   wire [4:0] slot_prev = slot - 5'd1;
   wire first_half = pair_first(op_reg, idx_reg);
   wire we_a = par_evt & ~first_half;
   wire we_b = par_evt & ~first_half & pend_reg;
   wire lcdc_addr_t pitch = {par_reg[`LCDC_SLOT_APH],
      par_reg[`LCDC_SLOT_APL]};
   wire lcdc_addr_t cursor_adv = cursor_step(cursor_reg, dir_reg, pitch);
   wire [22:0] sleep_load = 23'(`LCDC_SLEEP_TC) *
      23'(par_reg[`LCDC_SLOT_TCR]) * 23'(par_reg[`LCDC_SLOT_LF]) +
      23'(SLEEP_EXTRA_CYC);

   // bus address phase capture; hready marks the previous transfer done
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_act_reg <= 1'b0;
         dp_wr_reg <= 1'b0;
         dp_addr_reg <= 8'h00;
      end else if (hready) begin
         dp_act_reg <= take;
         dp_wr_reg <= hwrite;
         dp_addr_reg <= haddr[7:0];
      end
   end

   // memory reads take one wait state for the registered read data
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_wait_reg <= 1'b0;
      end else begin
         rd_wait_reg <= rd_issue;
      end
   end

   // memory port: writes go out on acceptance, reads on issue
   assign mem_bus.ce = (vram_wr_req & ~waking) | rd_issue;
   assign mem_bus.we = vram_wr_req;
   assign mem_bus.addr = cursor_reg;
   assign mem_bus.wdata = bus_byte;
   assign vram_chip_enable_n = ~mem_bus.ce;

   // command register, parameter index and pending half of a pair
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         op_reg <= `LCDC_RST_BYTE;
         idx_reg <= 4'd0;
         pend_reg <= 1'b0;
         pend_byte_reg <= `LCDC_RST_BYTE;
      end else if (cmd_evt) begin
         op_reg <= bus_byte;
         idx_reg <= 4'd0;
         pend_reg <= 1'b0; // lone half dropped
      end else if ((dat_evt || rd_done) && in_range) begin
         idx_reg <= idx_reg + 4'd1;
         if (par_evt) begin
            pend_reg <= first_half;
            pend_byte_reg <= bus_byte;
         end
      end
   end

   // parameter store, one byte per slot; a pair's first byte is written with its second
   genvar gi;
   generate
      for (gi = 0; gi < `LCDC_PAR_NUM; gi++) begin : g_par
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               par_reg[gi] <= `LCDC_RST_BYTE;
            end else if (we_a && slot == 5'(gi)) begin
               par_reg[gi] <= bus_byte;
            end else if (we_b && slot_prev == 5'(gi)) begin
               par_reg[gi] <= pend_byte_reg;
            end
         end
      end
   endgenerate

   // cursor address and advance direction
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cursor_reg <= `LCDC_RST_CURS;
         dir_reg <= 2'd0;
      end else if (cmd_evt && bus_byte[7:2] == 6'h13) begin
         dir_reg <= bus_byte[1:0];
      end else if (dat_evt && op_reg == `LCDC_OP_CURW && in_range) begin
         if (idx_reg == 4'd0) begin
            cursor_reg[7:0] <= bus_byte;
         end else begin
            cursor_reg[15:8] <= bus_byte;
         end
      end else if ((vram_wr_req && dat_evt) || (vram_rd_req && rd_done))
      begin
         cursor_reg <= cursor_adv;
      end
   end

   // display state: 0x59 turns on, 0x58 off, init blanks
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         disp_reg <= 1'b0;
      end else if (cmd_evt && (bus_byte == `LCDC_OP_DISP0 ||
            bus_byte == `LCDC_OP_DISP1)) begin
         disp_reg <= bus_byte[0];
      end else if (cmd_evt && bus_byte == `LCDC_OP_INIT) begin
         disp_reg <= 1'b0;
      end
   end

   // power sequencer: drain a frame into sleep, settle on wake
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pwr_reg <= PWR_RUN;
         pwr_cnt_reg <= 23'd0;
         panel_reg <= 1'b0;
      end else if (cmd_evt && bus_byte == `LCDC_OP_SLEEP) begin
         pwr_reg <= PWR_DRAIN;
         pwr_cnt_reg <= sleep_load;
      end else if (cmd_evt && bus_byte == `LCDC_OP_INIT) begin
         panel_reg <= 1'b1;
         if (pwr_reg != PWR_RUN) begin
            pwr_reg <= PWR_WAKE;
            pwr_cnt_reg <= 23'(WAKE_CYC);
         end
      end else begin
         case (pwr_reg)
            PWR_DRAIN: begin
               if (pwr_cnt_reg <= 23'd1) begin
                  pwr_reg <= PWR_SLEEP;
                  panel_reg <= 1'b0;
               end else begin
                  pwr_cnt_reg <= pwr_cnt_reg - 23'd1;
               end
            end
            PWR_WAKE: begin
               if (pwr_cnt_reg <= 23'd1) begin
                  pwr_reg <= PWR_RUN;
               end else begin
                  pwr_cnt_reg <= pwr_cnt_reg - 23'd1;
               end
            end
            PWR_SLEEP: pwr_reg <= PWR_SLEEP;
            default: pwr_reg <= PWR_RUN;
         endcase
      end
   end

   // shift strobe: divide-by-two enable toggles strobe, period four
   // clocks; init restarts the divider, sleep or a disabled panel parks
   // it low, since shifting columns into a switched-off panel is useless
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_reg <= 1'b0;
         strobe_reg <= 1'b0;
      end else if ((cmd_evt && bus_byte == `LCDC_OP_INIT) ||
            pwr_reg == PWR_SLEEP || !panel_reg) begin
         div_reg <= 1'b0;
         strobe_reg <= 1'b0;
      end else begin
         div_reg <= ~div_reg;
         if (div_reg) begin
            strobe_reg <= ~strobe_reg;
         end
      end
   end

   assign column_shift_strobe = strobe_reg;
   assign panel_power_disable = panel_reg;
   assign display_enable = disp_reg;

   // read mux; parameter window is one slot per word, the rest read zero
   wire [7:0] par_off = dp_addr_reg - `LCDC_PAR_OFS;
   wire par_hit = (dp_addr_reg >= `LCDC_PAR_OFS) &&
      (dp_addr_reg[1:0] == 2'b00) &&
      (par_off[7:2] < 6'(`LCDC_PAR_NUM));
   wire [31:0] status = {12'h000, idx_reg, op_reg, 1'b0,
      pend_reg, dir_reg, waking, pwr_reg == PWR_SLEEP, panel_reg,
      disp_reg};
   wire lcdc_byte_t cur_byte = (idx_reg == 4'd0) ? cursor_reg[7:0] :
      (idx_reg == 4'd1) ? cursor_reg[15:8] : 8'h00;
   wire lcdc_byte_t data_byte = (op_reg == `LCDC_OP_CURR) ? cur_byte :
      (op_reg == `LCDC_OP_MRD) ? mem_bus.rdata : 8'h00;
   wire [31:0] par_word = {24'h000000, par_reg[par_off[6:2]]};
   assign hrdata = (!dp_act_reg || dp_wr_reg) ? 32'h00000000 :
      (dp_addr_reg == `LCDC_DATA_OFS) ? {24'h000000, data_byte} :
      (dp_addr_reg == `LCDC_STAT_OFS) ? status :
      (dp_addr_reg == `LCDC_CURS_OFS) ? {16'h0000, cursor_reg} :
      par_hit ? par_word : 32'h00000000;
endmodule

/* logic/lcdc_map.svh */
// offsets, field positions, reset values and timing counts of the decoder
//
// Notes on behaviour
// - 0x40 initialises; up to eight parameters follow.
// - 0x53 sleeps; panel disable falls in time.
// - after wake, memory enable waits settling time.
// - 0x58/0x59 set display state; one parameter.
// - 0x44 sets start addresses; ten parameters.
// - 0x5C glyph base, 0x5D cursor shape; two bytes.
// - 0x4C-0x4F set advance direction; no parameters.
// - 0x5A sets pixel pan from one byte.
// - 0x5B sets layer mix from one byte.
// - 0x46 writes, 0x47 reads cursor, per byte.
// - 0x42 writes every data byte to memory.
// - 0x43 makes data reads return memory.
// - paired bytes commit together; lone half dropped.
// - pitch low and high bytes act separately.
// - each unpaired parameter byte takes effect on arrival.
// - new command keeps bytes already stored.
// - column shift strobe period is four clocks.
// - init resets timing, blanks display, cancels sleep.
`ifndef LCDC_MAP_SVH
`define LCDC_MAP_SVH

// bus offsets (byte addresses)
`define LCDC_CMD_OFS 8'h00
`define LCDC_DATA_OFS 8'h04
`define LCDC_STAT_OFS 8'h08
`define LCDC_CURS_OFS 8'h0c
`define LCDC_PAR_OFS 8'h40
`define LCDC_PAR_NUM 25

// opcodes
`define LCDC_OP_INIT 8'h40
`define LCDC_OP_SLEEP 8'h53
`define LCDC_OP_DISP0 8'h58
`define LCDC_OP_DISP1 8'h59
`define LCDC_OP_REGION 8'h44
`define LCDC_OP_GLYPH 8'h5c
`define LCDC_OP_SHAPE 8'h5d
`define LCDC_OP_PAN 8'h5a
`define LCDC_OP_MIX 8'h5b
`define LCDC_OP_CURW 8'h46
`define LCDC_OP_CURR 8'h47
`define LCDC_OP_MWR 8'h42
`define LCDC_OP_MRD 8'h43

// parameter slots in the parameter store
`define LCDC_BASE_INIT 5'd0
`define LCDC_BASE_REGION 5'd8
`define LCDC_BASE_GLYPH 5'd18
`define LCDC_BASE_SHAPE 5'd20
`define LCDC_BASE_DISP 5'd22
`define LCDC_BASE_PAN 5'd23
`define LCDC_BASE_MIX 5'd24
`define LCDC_SLOT_TCR 4
`define LCDC_SLOT_LF 5
`define LCDC_SLOT_APL 6
`define LCDC_SLOT_APH 7

// status fields
`define LCDC_ST_DISP 0
`define LCDC_ST_PANEL 1
`define LCDC_ST_SLEEP 2
`define LCDC_ST_WAKE 3
`define LCDC_ST_DIR 4
`define LCDC_ST_PEND 6
`define LCDC_ST_OP 8
`define LCDC_ST_IDX 16

// reset values
`define LCDC_RST_BYTE 8'h00
`define LCDC_RST_CURS 16'h0000

// timing
`define LCDC_TC_NS 50
`define LCDC_WAKE_TC 18
`define LCDC_WAKE_EXTRA_NS 40
`define LCDC_SLEEP_TC 36
`define LCDC_SLEEP_EXTRA_NS 70
`define LCDC_TOSS_NS 1000

`endif

/* logic/lcdc_mem_if.sv */
// link between the decoder and its display memory
`timescale 1ns/1ps
interface lcdc_mem_if;
   logic ce;
   logic we;
   logic [15:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport ctrl (output ce, output we, output addr, output wdata,
      input rdata);
   modport mem (input ce, input we, input addr, input wdata,
      output rdata);
endinterface

/* logic/lcdc_pkg.sv */
// types shared by the command decoder files
package lcdc_pkg;
   typedef logic [7:0] lcdc_byte_t;
   typedef logic [15:0] lcdc_addr_t;
   typedef enum logic [1:0] {
      PWR_RUN = 2'b00,
      PWR_DRAIN = 2'b01,
      PWR_SLEEP = 2'b10,
      PWR_WAKE = 2'b11
   } lcdc_pwr_e;
endpackage

/* logic/lcdc_vram.sv */
// display memory, one byte per address, registered read data
`timescale 1ns/1ps
module lcdc_vram (
   input wire logic hclk,
   lcdc_mem_if.mem port
);
   logic [7:0] mem_reg [0:65535];
   logic [7:0] rdata_reg;

   // no reset on the array: contents are undefined until written
   always_ff @(posedge hclk) begin
      if (port.ce && port.we) begin
         mem_reg[port.addr] <= port.wdata;
      end
      if (port.ce && !port.we) begin
         rdata_reg <= mem_reg[port.addr];
      end
   end

   assign port.rdata = rdata_reg;
endmodule

/* tb/lcdc_cmd_decoder_sva.sv */
// concurrent checks on the decoder's bus, power and shift strobe pins
`timescale 1ns/1ps
module lcdc_cmd_decoder_sva #(
   parameter int TOSS_NS = 1000
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic panel_power_disable,
   input wire logic vram_chip_enable_n,
   input wire logic column_shift_strobe,
   input wire logic display_enable
);
   // settle time in clocks; two clocks of slack for where counting starts
   localparam int WAKE_MIN = 16 + (TOSS_NS + 40 + 49) / 50;
   logic [7:0] since_wake;
   wire take = hsel && htrans[1] && hready;

   // clocks since the panel came back, saturating so it never wraps
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         since_wake <= 8'h00;
      end else if (!panel_power_disable) begin
         since_wake <= 8'h00;
      end else if (since_wake != 8'hff) begin
         since_wake <= since_wake + 8'h01;
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   resp_okay_a: assert property (hresp == 1'b0)
      else $error("bus response not okay");
   strobe_half_a: assert property (
      disable iff (!hresetn || !panel_power_disable)
      $rose(column_shift_strobe) |=> column_shift_strobe ##1
      !column_shift_strobe) else $error("strobe high phase not two");
   strobe_sleep_a: assert property (
      !panel_power_disable [*4] |-> !column_shift_strobe)
      else $error("strobe runs while panel off");
   stall_bound_a: assert property (!hreadyout |-> ##[1:60] hreadyout)
      else $error("bus stall too long");
   ce_pulse_a: assert property (
      !vram_chip_enable_n |=> vram_chip_enable_n)
      else $error("memory enable longer than one clock");
   wake_quiet_a: assert property (
      !vram_chip_enable_n |-> since_wake >= WAKE_MIN)
      else $error("memory enable before settle time");
   init_blank_a: assert property (
      $rose(panel_power_disable) |-> !display_enable)
      else $error("display on after init");
   write_nowait_a: assert property (
      take && hwrite && haddr[7:0] != 8'h04 |=> hreadyout)
      else $error("register write stalled");
   unmapped_zero_a: assert property (
      take && !hwrite && haddr[7:0] == 8'h10 |=> hreadyout && hrdata == 0)
      else $error("unmapped read not zero");

   cover property ($fell(panel_power_disable));
   cover property ($rose(panel_power_disable));
   cover property (!vram_chip_enable_n && !hreadyout);
endmodule

bind lcdc_cmd_decoder lcdc_cmd_decoder_sva #(.TOSS_NS(TOSS_NS))
   lcdc_cmd_decoder_sva_i (.hclk, .hresetn, .hsel, .haddr, .htrans,
   .hwrite, .hready, .hrdata, .hreadyout, .hresp, .panel_power_disable,
   .vram_chip_enable_n, .column_shift_strobe, .display_enable);

/* tb/lcdc_host.sv */
// host model: single-word bus master moving one byte per transfer
`timescale 1ns/1ps
module lcdc_host (
   input wire logic hclk,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata
);
   // idle bus from time zero
   initial begin
      {hsel, haddr, htrans, hwrite, hwdata} = '0;
      hsize = 3'h2;
   end

   // address phase held until taken, then data phase held until ready
   task automatic xfer(input logic wr, input logic [7:0] a,
         input logic [7:0] v, output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= wr;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= {24'h0, v};
      do @(posedge hclk); while (hready !== 1'b1);
      q = hrdata;
   endtask
endmodule

/* tb/test_lcdc_cmd_decoder.sv */
// self-checking bench for the command decoder
`timescale 1ns/1ps
`include "lcdc_map.svh"
`define CHK(g, e) begin \
   tests_run++; \
   if ((g) !== (e)) begin \
      error_cnt++; \
      $display("Error at %0t: got %h expected %h", $time, g, e); \
   end \
end
module test_lcdc_cmd_decoder import lcdc_pkg::*;;
   localparam int TOSS = 100;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel, hwrite, hreadyout, hresp, panel, ce_n, strobe, disp;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [11:0] sb;
   lcdc_byte_t par [25];
   lcdc_byte_t d, v;
   lcdc_addr_t e;
   lcdc_byte_t ops [4] = '{8'h5a, 8'h5b, 8'h59, 8'h58};
   int slot [4] = '{23, 24, 22, 22};
   int n;
   int error_cnt = 0;
   int tests_run = 0;

   lcdc_cmd_decoder #(.TOSS_NS(TOSS)) lcdc_cmd_decoder_i (.hclk, .hresetn,
      .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
      .hrdata, .hreadyout, .hresp, .panel_power_disable(panel),
      .vram_chip_enable_n(ce_n), .column_shift_strobe(strobe),
      .display_enable(disp));
   lcdc_host lcdc_host_i (.hclk, .hready(hreadyout), .hrdata, .hsel,
      .haddr, .htrans, .hwrite, .hsize, .hwdata);

   // 20 MHz clock
   initial forever #25 hclk = ~hclk;

   // hang guard, far beyond the thousand or so clocks the tests need
   initial begin
      repeat (20000) @(posedge hclk);
      error_cnt++;
      report_and_stop();
   end

   task automatic report_and_stop();
      $display("checks %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input lcdc_byte_t b);
      lcdc_host_i.xfer(1'b1, a, b, q);
   endtask

   task automatic rd(input logic [7:0] a);
      lcdc_host_i.xfer(1'b0, a, 8'h00, q);
   endtask

   // opcode, then n random bytes of which the first cnt are kept
   task automatic send(input lcdc_byte_t op, input int base, input int cnt,
         input int n);
      wr(`LCDC_CMD_OFS, op);
      for (int i = 0; i < n; i++) begin
         d = 8'($urandom);
         if (op == `LCDC_OP_INIT &&
               (i == `LCDC_SLOT_TCR || i == `LCDC_SLOT_LF)) begin
            d = 8'(1 + $urandom % 3);
         end
         wr(`LCDC_DATA_OFS, d);
         if (base >= 0 && i < cnt) begin
            par[base + i] = d;
         end
      end
   endtask

   task automatic set_cur();
      send(`LCDC_OP_CURW, -1, 0, 0);
      wr(`LCDC_DATA_OFS, 8'h00);
      wr(`LCDC_DATA_OFS, 8'h80);
   endtask

   task automatic check_par();
      for (int i = 0; i < `LCDC_PAR_NUM; i++) begin
         rd(`LCDC_PAR_OFS + 8'(4 * i));
         `CHK(q[7:0], par[i])
      end
   endtask

   // cursor step for each advance direction; pitch spans two slots
   function automatic lcdc_addr_t cur_next(lcdc_addr_t c, logic [1:0] r);
      case (r)
         2'd0: return c + 16'h1;
         2'd1: return c - 16'h1;
         2'd2: return c - {par[`LCDC_SLOT_APH], par[`LCDC_SLOT_APL]};
         default: return c + {par[`LCDC_SLOT_APH], par[`LCDC_SLOT_APL]};
      endcase
   endfunction

   // the 70 ns tail rounds up to two clocks at this rate
   function automatic int sleep_max();
      return `LCDC_SLEEP_TC * par[`LCDC_SLOT_TCR] * par[`LCDC_SLOT_LF] + 2;
   endfunction

   // main sequence
   initial begin
      void'($urandom(42));
      foreach (par[i]) par[i] = `LCDC_RST_BYTE;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      check_par();
      rd(8'h10);
      `CHK(q, 32'h0)
      send(`LCDC_OP_INIT, 0, 8, 9);
      check_par();
      `CHK({panel, disp}, 2'b10)
      for (int k = 0; k < 4; k++) begin
         send(ops[k], slot[k], 1, 2);
         rd(`LCDC_STAT_OFS);
         `CHK(disp, k == 2)
         `CHK(q[15:8], ops[k])
      end
      check_par();
      send(`LCDC_OP_GLYPH, 18, 2, 3);
      send(`LCDC_OP_SHAPE, 20, 2, 3);
      send(`LCDC_OP_GLYPH, -1, 0, 1);
      send(`LCDC_OP_REGION, -1, 0, 1);
      send(`LCDC_OP_MIX, 24, 1, 1);
      check_par();
      send(`LCDC_OP_REGION, 8, 10, 11);
      send(`LCDC_OP_REGION, 8, 3, 3);
      send(`LCDC_OP_PAN, 23, 1, 1);
      check_par();
      for (int k = 0; k < 4; k++) begin
         send(8'h4c | 8'(k), -1, 0, 0);
         rd(`LCDC_STAT_OFS);
         `CHK(q[5:4], 2'(k))
         set_cur();
         send(`LCDC_OP_MWR, -1, 0, 1);
         v = d;
         e = cur_next(16'h8000, 2'(k));
         rd(`LCDC_CURS_OFS);
         `CHK(q[15:0], e)
         set_cur();
         send(`LCDC_OP_MRD, -1, 0, 0);
         rd(`LCDC_DATA_OFS);
         `CHK(q[7:0], v)
         send(`LCDC_OP_CURW, -1, 0, 1);
         send(`LCDC_OP_CURR, -1, 0, 0);
         rd(`LCDC_DATA_OFS);
         `CHK(q[7:0], d)
         rd(`LCDC_DATA_OFS);
         `CHK(q[7:0], e[15:8])
      end
      for (int i = 0; i < 12; i++) begin
         @(posedge hclk);
         sb[i] = strobe;
      end
      for (int i = 0; i < 8; i++) `CHK(sb[i], sb[i + 4])
      `CHK($countones(sb[3:0]), 2)
      n = 0;
      wr(`LCDC_CMD_OFS, `LCDC_OP_SLEEP);
      while (panel === 1'b1 && n < 1000) begin
         @(posedge hclk);
         n++;
      end
      `CHK(n <= sleep_max(), 1'b1)
      repeat (8) @(posedge hclk);
      `CHK(strobe, 1'b0)
      wr(`LCDC_CMD_OFS, `LCDC_OP_INIT);
      @(posedge hclk);
      `CHK({panel, disp}, 2'b10)
      set_cur();
      send(`LCDC_OP_MWR, -1, 0, 1);
      rd(`LCDC_CURS_OFS);
      `CHK(q[15:0], cur_next(16'h8000, 2'd3))
      check_par();
      report_and_stop();
   end
endmodule
